// file: src/pms_pkg.sv
// shared constants and types of the pwm module supervisor
package pms_pkg;
	// clock and timing
	localparam int CLK_HZ        = 125_000_000;  // core clock rate
	localparam int HWD_UNIT_MS   = 100;          // host watchdog unit, 0.1 s
	localparam int HWD_UNIT_CYC  = CLK_HZ / 1000 * HWD_UNIT_MS;
	localparam int MWD_TIME_MS   = 500;          // module watchdog window
	localparam int MWD_CYC       = CLK_HZ / 1000 * MWD_TIME_MS;
	localparam logic [1:0] STRAP_SETTLE = 2'h3;  // cycles before strap capture

	// channel data widths
	localparam int FREQ_W = 24;                  // frequency in hz
	localparam int DUTY_W = 10;                  // duty in 0.1 percent

	// register byte offsets
	localparam logic [7:0] OFS_CTRL     = 8'h00;
	localparam logic [7:0] OFS_HWD_TMO  = 8'h04;
	localparam logic [7:0] OFS_STATUS   = 8'h08;
	localparam logic [7:0] OFS_COMM     = 8'h0c;
	localparam logic [7:0] OFS_DO_PWRON = 8'h10;
	localparam logic [7:0] OFS_DO_SAFE  = 8'h14;
	localparam logic [7:0] OFS_DO_VAL   = 8'h18;
	localparam logic [7:0] OFS_CH_SEL   = 8'h20;
	localparam logic [7:0] OFS_CH_FREQ  = 8'h24;
	localparam logic [7:0] OFS_CH_DUTY  = 8'h28;

	// field positions
	localparam int CTRL_HWD_EN  = 0;
	localparam int CTRL_RUN_LSB = 8;
	localparam int ST_INIT      = 8;
	localparam int ST_LOADED    = 9;
	localparam int ST_RST_FLAG  = 10;
	localparam int ST_SAVING    = 11;
	localparam int ST_REJECT    = 12;

	// module status codes
	localparam logic [7:0] MS_OK      = 8'h00;
	localparam logic [7:0] MS_HWD_TMO = 8'h04;

	// factory communication settings used in init mode
	localparam logic [7:0] INIT_NODE_ADDR = 8'h00;
	localparam logic [5:0] INIT_BAUD_CODE = 6'h06;   // 9600 bps
	localparam logic       INIT_CHECKSUM  = 1'b0;
	localparam logic       INIT_PROTOCOL  = 1'b0;    // ascii command set

	// reset values of stored settings
	localparam logic [7:0] RST_NODE_ADDR = 8'h01;
	localparam logic [5:0] RST_BAUD_CODE = 6'h06;

	// frequency bands and duty limits
	localparam logic [FREQ_W-1:0] FREQ_FINE_MAX   = 24'h0003e8;  // 1000 hz
	localparam logic [FREQ_W-1:0] FREQ_COARSE_MAX = 24'h002710;  // 10000 hz
	localparam logic [DUTY_W-1:0] DUTY_FINE_MIN   = 10'h001;     // 0.1 %
	localparam logic [DUTY_W-1:0] DUTY_FINE_MAX   = 10'h3e7;     // 99.9 %
	localparam logic [DUTY_W-1:0] DUTY_CRS_MIN    = 10'h00a;     // 1 %
	localparam logic [DUTY_W-1:0] DUTY_CRS_MAX    = 10'h3de;     // 99 %
	localparam logic [DUTY_W-1:0] DUTY_CRS_STEP   = 10'h00a;     // 1 %
	localparam logic [DUTY_W-1:0] DUTY_HALF       = 10'h1f4;     // 50 %

	// reply characters
	localparam logic [7:0] RESP_VALID   = 8'h21;
	localparam logic [7:0] RESP_INVALID = 8'h3f;

	// decoded host commands
	typedef enum logic [2:0] {
		CMD_OTHER              = 3'b000,
		CMD_SET_DIGITAL_OUTPUT = 3'b001,
		CMD_CLEAR_MODULE_STAT  = 3'b010,
		CMD_SAVE_PWM_CONFIG    = 3'b011,
		CMD_READ_RESET_STATUS  = 3'b100,
		CMD_SET_COMM_CONFIG    = 3'b101,
		CMD_SELECT_PROTOCOL    = 3'b110
	} pms_cmd_t;

	// nonvolatile transfer states
	typedef enum logic [1:0] {
		NV_LOAD  = 2'b00,
		NV_READY = 2'b01,
		NV_SAVE  = 2'b10
	} pms_nv_t;
endpackage : pms_pkg

// file: src/pms_supervisor.sv
// pwm module supervisor: output gating, watchdogs, config storage
`timescale 1ns/1ns
module pms_supervisor #(
	parameter int NCH          = 8,                     // pwm channels
	parameter int DO_W         = 8,                     // digital outputs
	parameter int HWD_UNIT_CYC = pms_pkg::HWD_UNIT_CYC, // 0.1 s in cycles
	parameter int MWD_CYC      = pms_pkg::MWD_CYC       // module watchdog
) (
	input  wire logic                            clk_i,
	input  wire logic                            rst_i,
	input  wire logic                            wb_cyc_i,
	input  wire logic                            wb_stb_i,
	input  wire logic                            wb_we_i,
	input  wire logic [7:0]                      wb_adr_i,
	input  wire logic [3:0]                      wb_sel_i,
	input  wire logic [31:0]                     wb_dat_i,
	output logic      [31:0]                     wb_dat_o,
	output logic                                 wb_ack_o,
	input  wire logic                            cmd_valid_i,
	input  wire pms_pkg::pms_cmd_t               cmd_code_i,
	input  wire logic [15:0]                     cmd_data_i,
	output logic                                 resp_valid_o,
	output logic                                 resp_ok_o,
	output logic      [7:0]                      resp_data_o,
	output logic                                 nvm_req_o,
	output logic                                 nvm_we_o,
	output logic      [$clog2(NCH)-1:0]          nvm_addr_o,
	output logic      [pms_pkg::FREQ_W+pms_pkg::DUTY_W-1:0] nvm_wdata_o,
	input  wire logic [pms_pkg::FREQ_W+pms_pkg::DUTY_W-1:0] nvm_rdata_i,
	input  wire logic                            nvm_ack_i,
	input  wire logic                            init_n_i,
	input  wire logic                            mwd_kick_i,
	output logic                                 mwd_reset_o,
	output logic      [NCH-1:0]                  pwm_run_o,
	output logic      [NCH*pms_pkg::FREQ_W-1:0]  pwm_freq_o,
	output logic      [NCH*pms_pkg::DUTY_W-1:0]  pwm_duty_o,
	output logic      [DO_W-1:0]                 do_o,
	output logic      [7:0]                      node_addr_o,
	output logic      [5:0]                      baud_code_o,
	output logic                                 checksum_o,
	output logic                                 protocol_o,
	output logic                                 init_mode_o
);
	localparam int FW     = pms_pkg::FREQ_W;
	localparam int DW     = pms_pkg::DUTY_W;
	localparam int CH_AW  = $clog2(NCH);
	localparam int TICK_W = $clog2(HWD_UNIT_CYC + 1);
	localparam int MWD_W  = $clog2(MWD_CYC + 1);

	// bus group
	logic            ack_reg, ack_next;        // registered acknowledge
	logic [31:0]     dat_reg, dat_next;        // registered read data
	logic [31:0]     rd_word;                  // addressed register value
	logic [31:0]     wmask;                    // byte lane mask
	logic [31:0]     wval;                     // merged write value
	logic            wb_req;                   // new request this cycle
	logic            wb_wr;                    // write taken this cycle

	// init strap synchroniser and capture
	logic            strap_s1_reg, strap_s2_reg;
	logic [1:0]      strap_cnt_reg, strap_cnt_next;
	logic            init_reg, init_next;

	// supervisor state
	logic [7:0]      mstat_reg, mstat_next;    // module status code
	logic            hwd_en_reg, hwd_en_next;
	logic [7:0]      hwd_tmo_reg, hwd_tmo_next;
	logic [7:0]      hwd_cnt_reg, hwd_cnt_next;
	logic [TICK_W-1:0] tick_reg, tick_next;
	logic [MWD_W-1:0]  mwd_cnt_reg, mwd_cnt_next;
	logic            mwd_rst_reg, mwd_rst_next;
	logic            rflag_reg, rflag_next;    // reset status flag
	logic            reject_reg, reject_next;  // rejected duty write
	logic [NCH-1:0]  run_reg, run_next;
	logic [DO_W-1:0] do_reg, do_next;
	logic [DO_W-1:0] do_pwron_reg, do_pwron_next;
	logic [DO_W-1:0] do_safe_reg, do_safe_next;
	logic [7:0]      saddr_reg, saddr_next;    // stored node address
	logic [5:0]      sbaud_reg, sbaud_next;
	logic            scsum_reg, scsum_next;
	logic            sproto_reg, sproto_next;
	logic [7:0]      oaddr_reg, oaddr_next;    // effective settings
	logic [5:0]      obaud_reg, obaud_next;
	logic            ocsum_reg, ocsum_next;
	logic            oproto_reg, oproto_next;
	logic            rsp_v_reg, rsp_v_next;
	logic            rsp_ok_reg, rsp_ok_next;
	logic [7:0]      rsp_d_reg, rsp_d_next;
	logic [CH_AW-1:0] chsel_reg, chsel_next;
	logic [FW-1:0]   fstage_reg, fstage_next;  // frequency waiting for duty
	logic [NCH-1:0][FW-1:0] freq_reg, freq_next;
	logic [NCH-1:0][DW-1:0] duty_reg, duty_next;
	pms_pkg::pms_nv_t nv_reg, nv_next;
	logic [CH_AW-1:0] nvch_reg, nvch_next;
	logic            nreq_reg, nreq_next;
	logic            nwe_reg, nwe_next;
	logic [FW+DW-1:0] nwd_reg, nwd_next;
	logic            hwd_fire;                 // host timeout event
	logic            loaded;                   // storage load finished

	assign loaded = (nv_reg != pms_pkg::NV_LOAD);

	// duty check against the frequency band it will run in
	function automatic logic pms_duty_ok(input logic [FW-1:0] f,
	                                     input logic [DW-1:0] d);
		logic ok;
		ok = 1'b0;
		if (f == '0) begin
			ok = 1'b0;                            // zero hz is no setting
		end else if (f <= pms_pkg::FREQ_FINE_MAX) begin
			ok = (d >= pms_pkg::DUTY_FINE_MIN) &&
			     (d <= pms_pkg::DUTY_FINE_MAX);
		end else if (f <= pms_pkg::FREQ_COARSE_MAX) begin
			ok = (d >= pms_pkg::DUTY_CRS_MIN) && (d <= pms_pkg::DUTY_CRS_MAX)
			     && ((d % pms_pkg::DUTY_CRS_STEP) == '0);
		end else begin
			ok = 1'b1;                            // duty replaced by half
		end
		return ok;
	endfunction : pms_duty_ok

	// read mux and bus answer; ack always one cycle after the request
	always_comb begin
		rd_word = 32'h0;
		case (wb_adr_i)
			pms_pkg::OFS_CTRL: begin
				rd_word[pms_pkg::CTRL_HWD_EN] = hwd_en_reg;
				rd_word[pms_pkg::CTRL_RUN_LSB +: NCH] = run_reg;
			end
			pms_pkg::OFS_HWD_TMO: rd_word[7:0] = hwd_tmo_reg;
			pms_pkg::OFS_STATUS: begin
				rd_word[7:0] = mstat_reg;
				rd_word[pms_pkg::ST_INIT] = init_reg;
				rd_word[pms_pkg::ST_LOADED] = loaded;
				rd_word[pms_pkg::ST_RST_FLAG] = rflag_reg;
				rd_word[pms_pkg::ST_SAVING] = (nv_reg == pms_pkg::NV_SAVE);
				rd_word[pms_pkg::ST_REJECT] = reject_reg;
			end
			// stored settings, unchanged by init mode
			pms_pkg::OFS_COMM: rd_word[15:0] = {sproto_reg, scsum_reg,
			                                    sbaud_reg, saddr_reg};
			pms_pkg::OFS_DO_PWRON: rd_word[DO_W-1:0] = do_pwron_reg;
			pms_pkg::OFS_DO_SAFE: rd_word[DO_W-1:0] = do_safe_reg;
			pms_pkg::OFS_DO_VAL: rd_word[DO_W-1:0] = do_reg;
			pms_pkg::OFS_CH_SEL: rd_word[CH_AW-1:0] = chsel_reg;
			pms_pkg::OFS_CH_FREQ: rd_word[FW-1:0] = freq_reg[chsel_reg];
			pms_pkg::OFS_CH_DUTY: rd_word[DW-1:0] = duty_reg[chsel_reg];
			default: rd_word = 32'h0;             // unmapped reads zero
		endcase
		wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
		         {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
		wval = (rd_word & ~wmask) | (wb_dat_i & wmask);
		// ack_reg gap keeps one ack per classic cycle
		wb_req = wb_cyc_i && wb_stb_i && !ack_reg;
		wb_wr = wb_req && wb_we_i;
		ack_next = wb_req;
		dat_next = (wb_req && !wb_we_i) ? rd_word : 32'h0;
	end

	// bus registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
			dat_reg <= 32'h0;
		end else begin
			ack_reg <= ack_next;
			dat_reg <= dat_next;
		end
	end

	// strap pin passes two flops before anything reads it
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			strap_s1_reg <= 1'b1;
			strap_s2_reg <= 1'b1;
		end else begin
			strap_s1_reg <= init_n_i;
			strap_s2_reg <= strap_s1_reg;
		end
	end

	// supervisor next state
	always_comb begin
		strap_cnt_next = strap_cnt_reg;
		init_next = init_reg;
		mstat_next = mstat_reg;
		hwd_en_next = hwd_en_reg;
		hwd_tmo_next = hwd_tmo_reg;
		hwd_cnt_next = hwd_cnt_reg;
		tick_next = tick_reg;
		mwd_cnt_next = mwd_cnt_reg;
		mwd_rst_next = 1'b0;
		rflag_next = rflag_reg;
		reject_next = reject_reg;
		run_next = run_reg;
		do_next = do_reg;
		do_pwron_next = do_pwron_reg;
		do_safe_next = do_safe_reg;
		saddr_next = saddr_reg;
		sbaud_next = sbaud_reg;
		scsum_next = scsum_reg;
		sproto_next = sproto_reg;
		rsp_v_next = 1'b0;
		rsp_ok_next = 1'b0;
		rsp_d_next = 8'h00;
		chsel_next = chsel_reg;
		fstage_next = fstage_reg;
		freq_next = freq_reg;
		duty_next = duty_reg;
		nv_next = nv_reg;
		nvch_next = nvch_reg;
		hwd_fire = 1'b0;

		// strap caught once, after the synchroniser has filled
		if (strap_cnt_reg != pms_pkg::STRAP_SETTLE) begin
			strap_cnt_next = strap_cnt_reg + 2'h1;
			if (strap_cnt_reg == pms_pkg::STRAP_SETTLE - 2'h1) begin
				init_next = !strap_s2_reg;
			end
		end

		// host watchdog: any command reloads the count
		if (!hwd_en_reg || mstat_reg == pms_pkg::MS_HWD_TMO) begin
			tick_next = '0;
			hwd_cnt_next = hwd_tmo_reg;
		end else if (cmd_valid_i) begin
			tick_next = '0;
			hwd_cnt_next = hwd_tmo_reg;
		end else if (tick_reg == TICK_W'(HWD_UNIT_CYC - 1)) begin
			tick_next = '0;
			if (hwd_cnt_reg == 8'h00) begin
				hwd_fire = 1'b1;
			end else begin
				hwd_cnt_next = hwd_cnt_reg - 8'h01;   // tenths of a second
			end
		end else begin
			tick_next = tick_reg + TICK_W'(1);
		end

		// host commands; each gets exactly one reply
		if (cmd_valid_i) begin
			rsp_v_next = 1'b1;
			rsp_ok_next = 1'b1;
			rsp_d_next = pms_pkg::RESP_VALID;
			case (cmd_code_i)
				pms_pkg::CMD_SET_DIGITAL_OUTPUT: begin
					if (mstat_reg == pms_pkg::MS_HWD_TMO) begin
						rsp_ok_next = 1'b0;           // discarded
						rsp_d_next = pms_pkg::RESP_INVALID;
					end else begin
						do_next = cmd_data_i[DO_W-1:0];
					end
				end
				pms_pkg::CMD_CLEAR_MODULE_STAT: begin
					mstat_next = pms_pkg::MS_OK;
				end
				pms_pkg::CMD_SAVE_PWM_CONFIG: begin
					// a save needs the channel walk to be idle
					if (nv_reg != pms_pkg::NV_READY) begin
						rsp_ok_next = 1'b0;
						rsp_d_next = pms_pkg::RESP_INVALID;
					end else begin
						nv_next = pms_pkg::NV_SAVE;
						nvch_next = '0;
					end
				end
				pms_pkg::CMD_READ_RESET_STATUS: begin
					rsp_d_next = {7'h00, rflag_reg};
					rflag_next = 1'b0;
				end
				pms_pkg::CMD_SET_COMM_CONFIG: begin
					if (!init_reg) begin
						rsp_ok_next = 1'b0;
						rsp_d_next = pms_pkg::RESP_INVALID;
					end else begin
						saddr_next = cmd_data_i[15:8];
						sbaud_next = cmd_data_i[5:0];
						scsum_next = cmd_data_i[6];
					end
				end
				pms_pkg::CMD_SELECT_PROTOCOL: begin
					if (!init_reg) begin
						rsp_ok_next = 1'b0;
						rsp_d_next = pms_pkg::RESP_INVALID;
					end else begin
						sproto_next = cmd_data_i[0];
					end
				end
				default: begin
					rsp_ok_next = 1'b1;               // handled elsewhere
				end
			endcase
		end

		// software register writes
		if (wb_wr) begin
			case (wb_adr_i)
				pms_pkg::OFS_CTRL: begin
					hwd_en_next = wval[pms_pkg::CTRL_HWD_EN];
					// stopping is always allowed, starting is not
					if (mstat_reg == pms_pkg::MS_HWD_TMO || !loaded) begin
						run_next = run_reg & wval[pms_pkg::CTRL_RUN_LSB +: NCH];
					end else begin
						run_next = wval[pms_pkg::CTRL_RUN_LSB +: NCH];
					end
				end
				pms_pkg::OFS_HWD_TMO: hwd_tmo_next = wval[7:0];
				pms_pkg::OFS_STATUS: begin
					if (wval[pms_pkg::ST_REJECT]) begin
						reject_next = 1'b0;
					end
				end
				pms_pkg::OFS_DO_PWRON: do_pwron_next = wval[DO_W-1:0];
				pms_pkg::OFS_DO_SAFE: do_safe_next = wval[DO_W-1:0];
				pms_pkg::OFS_CH_SEL: chsel_next = wval[CH_AW-1:0];
				pms_pkg::OFS_CH_FREQ: fstage_next = wval[FW-1:0];
				pms_pkg::OFS_CH_DUTY: begin
					// the pair commits only when it fits its band
					if (loaded && pms_duty_ok(fstage_reg, wval[DW-1:0])) begin
						freq_next[chsel_reg] = fstage_reg;
						if (fstage_reg > pms_pkg::FREQ_COARSE_MAX) begin
							duty_next[chsel_reg] = pms_pkg::DUTY_HALF;
						end else begin
							duty_next[chsel_reg] = wval[DW-1:0];
						end
					end else begin
						reject_next = 1'b1;               // set wins over clear
					end
				end
				default: begin
					hwd_en_next = hwd_en_next;        // unmapped writes ignored
				end
			endcase
		end

		// host timeout: stop everything and hold it stopped
		if (hwd_fire) begin
			mstat_next = pms_pkg::MS_HWD_TMO;
			run_next = '0;
			do_next = do_safe_reg;
		end

		// module watchdog: a missing kick resets the device
		if (mwd_kick_i) begin
			mwd_cnt_next = '0;
		end else if (mwd_cnt_reg == MWD_W'(MWD_CYC - 1)) begin
			mwd_cnt_next = '0;
			mwd_rst_next = 1'b1;
			rflag_next = 1'b1;                        // beats a clear
			do_next = do_pwron_reg;
			run_next = '0;
		end else begin
			mwd_cnt_next = mwd_cnt_reg + MWD_W'(1);
		end

		// channel walk to and from nonvolatile storage
		case (nv_reg)
			pms_pkg::NV_LOAD: begin
				if (nvm_ack_i) begin
					freq_next[nvch_reg] = nvm_rdata_i[FW+DW-1:DW];
					duty_next[nvch_reg] = nvm_rdata_i[DW-1:0];
					if (nvch_reg == CH_AW'(NCH - 1)) begin
						nv_next = pms_pkg::NV_READY;
						nvch_next = '0;
					end else begin
						nvch_next = nvch_reg + CH_AW'(1);
					end
				end
			end
			pms_pkg::NV_SAVE: begin
				if (nvm_ack_i) begin
					if (nvch_reg == CH_AW'(NCH - 1)) begin
						nv_next = pms_pkg::NV_READY;
						nvch_next = '0;
					end else begin
						nvch_next = nvch_reg + CH_AW'(1);
					end
				end
			end
			pms_pkg::NV_READY: nvch_next = nvch_reg;
			default: nv_next = pms_pkg::NV_READY;
		endcase
		nreq_next = (nv_next != pms_pkg::NV_READY);
		nwe_next = (nv_next == pms_pkg::NV_SAVE);
		nwd_next = {freq_next[nvch_next], duty_next[nvch_next]};

		// init mode overrides only what goes out, never the store
		if (init_next) begin
			oaddr_next = pms_pkg::INIT_NODE_ADDR;
			obaud_next = pms_pkg::INIT_BAUD_CODE;
			ocsum_next = pms_pkg::INIT_CHECKSUM;
			oproto_next = pms_pkg::INIT_PROTOCOL;
		end else begin
			oaddr_next = saddr_next;
			obaud_next = sbaud_next;
			ocsum_next = scsum_next;
			oproto_next = sproto_next;
		end
	end

	// supervisor registers; reset is power-on, flag set and outputs off
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			strap_cnt_reg <= 2'h0;
			init_reg <= 1'b0;
			mstat_reg <= pms_pkg::MS_OK;
			hwd_en_reg <= 1'b0;
			hwd_tmo_reg <= 8'h00;
			hwd_cnt_reg <= 8'h00;
			tick_reg <= '0;
			mwd_cnt_reg <= '0;
			mwd_rst_reg <= 1'b0;
			rflag_reg <= 1'b1;
			reject_reg <= 1'b0;
			run_reg <= '0;
			do_reg <= '0;                             // power-on value is zero
			do_pwron_reg <= '0;
			do_safe_reg <= '0;
			saddr_reg <= pms_pkg::RST_NODE_ADDR;
			sbaud_reg <= pms_pkg::RST_BAUD_CODE;
			scsum_reg <= 1'b0;
			sproto_reg <= 1'b0;
			oaddr_reg <= pms_pkg::RST_NODE_ADDR;
			obaud_reg <= pms_pkg::RST_BAUD_CODE;
			ocsum_reg <= 1'b0;
			oproto_reg <= 1'b0;
			rsp_v_reg <= 1'b0;
			rsp_ok_reg <= 1'b0;
			rsp_d_reg <= 8'h00;
			chsel_reg <= '0;
			fstage_reg <= '0;
			freq_reg <= '0;
			duty_reg <= '0;
			nv_reg <= pms_pkg::NV_LOAD;
			nvch_reg <= '0;
			nreq_reg <= 1'b0;
			nwe_reg <= 1'b0;
			nwd_reg <= '0;
		end else begin
			strap_cnt_reg <= strap_cnt_next;
			init_reg <= init_next;
			mstat_reg <= mstat_next;
			hwd_en_reg <= hwd_en_next;
			hwd_tmo_reg <= hwd_tmo_next;
			hwd_cnt_reg <= hwd_cnt_next;
			tick_reg <= tick_next;
			mwd_cnt_reg <= mwd_cnt_next;
			mwd_rst_reg <= mwd_rst_next;
			rflag_reg <= rflag_next;
			reject_reg <= reject_next;
			run_reg <= run_next;
			do_reg <= do_next;
			do_pwron_reg <= do_pwron_next;
			do_safe_reg <= do_safe_next;
			saddr_reg <= saddr_next;
			sbaud_reg <= sbaud_next;
			scsum_reg <= scsum_next;
			sproto_reg <= sproto_next;
			oaddr_reg <= oaddr_next;
			obaud_reg <= obaud_next;
			ocsum_reg <= ocsum_next;
			oproto_reg <= oproto_next;
			rsp_v_reg <= rsp_v_next;
			rsp_ok_reg <= rsp_ok_next;
			rsp_d_reg <= rsp_d_next;
			chsel_reg <= chsel_next;
			fstage_reg <= fstage_next;
			freq_reg <= freq_next;
			duty_reg <= duty_next;
			nv_reg <= nv_next;
			nvch_reg <= nvch_next;
			nreq_reg <= nreq_next;
			nwe_reg <= nwe_next;
			nwd_reg <= nwd_next;
		end
	end

	// every output is a flop
	assign wb_ack_o     = ack_reg;
	assign wb_dat_o     = dat_reg;
	assign resp_valid_o = rsp_v_reg;
	assign resp_ok_o    = rsp_ok_reg;
	assign resp_data_o  = rsp_d_reg;
	assign nvm_req_o    = nreq_reg;
	assign nvm_we_o     = nwe_reg;
	assign nvm_addr_o   = nvch_reg;
	assign nvm_wdata_o  = nwd_reg;
	assign mwd_reset_o  = mwd_rst_reg;
	assign pwm_run_o    = run_reg;
	assign pwm_freq_o   = freq_reg;
	assign pwm_duty_o   = duty_reg;
	assign do_o         = do_reg;
	assign node_addr_o  = oaddr_reg;
	assign baud_code_o  = obaud_reg;
	assign checksum_o   = ocsum_reg;
	assign protocol_o   = oproto_reg;
	assign init_mode_o  = init_reg;
endmodule : pms_supervisor

// file: test/pms_nvm_model.sv
// storage model answering word reads and writes of the supervisor
`timescale 1ns/1ns
module pms_nvm_model (
	input  wire logic        clk_i,
	input  wire logic        req_i,
	input  wire logic        we_i,
	input  wire logic [2:0]  addr_i,
	input  wire logic [33:0] wdata_i,
	output logic             ack_o,
	output logic [33:0]      rdata_o
);
	logic [33:0] mem [8];  // one word per channel
	logic [1:0]  cnt_reg;  // answers every fourth cycle, never instantly
	initial begin
		ack_o = 1'b0;
		rdata_o = 34'h0;
		cnt_reg = 2'h0;
		foreach (mem[i]) mem[i] = {24'h0001f4, 10'h1f4};
	end
	// data line shows a changing pattern outside the ack cycle
	always @(posedge clk_i) begin
		cnt_reg <= cnt_reg + 2'h1;
		ack_o <= req_i && (cnt_reg == 2'h3) && !ack_o;
		rdata_o <= ~rdata_o;
		if (req_i && (cnt_reg == 2'h3) && !ack_o) begin
			rdata_o <= mem[addr_i];
			if (we_i) mem[addr_i] <= wdata_i;
		end
	end
endmodule : pms_nvm_model

// file: test/pms_supervisor_monitor.sv
// assertions on the supervisor ports
`timescale 1ns/1ns
module pms_supervisor_monitor #(
	parameter int NCH  = 8,
	parameter int DO_W = 8
) (
	input wire logic              clk_i,
	input wire logic              rst_i,
	input wire logic              cmd_valid_i,
	input wire pms_pkg::pms_cmd_t cmd_code_i,
	input wire logic              resp_ok_o,
	input wire logic              resp_valid_o,
	input wire logic [7:0]        resp_data_o,
	input wire logic              nvm_req_o,
	input wire logic              nvm_we_o,
	input wire logic              mwd_reset_o,
	input wire logic [NCH-1:0]    pwm_run_o,
	input wire logic [DO_W-1:0]   do_o,
	input wire logic              init_mode_o,
	input wire logic [7:0]        node_addr_o,
	input wire logic [5:0]        baud_code_o,
	input wire logic              checksum_o,
	input wire logic              protocol_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	property p_off; $fell(rst_i) |-> pwm_run_o == '0; endproperty
	a_off: assert property (p_off) else $error("run after reset");
	property p_load; $fell(rst_i) |-> ##[0:2] nvm_req_o && !nvm_we_o;
	endproperty
	a_load: assert property (p_load) else $error("no load");
	property p_inv; resp_valid_o && !resp_ok_o |-> resp_data_o == 8'h3f;
	endproperty
	a_inv: assert property (p_inv) else $error("bad refusal");
	property p_mwd; mwd_reset_o |-> ##1 pwm_run_o == '0; endproperty
	a_mwd: assert property (p_mwd) else $error("run after wdt");
	property p_init; init_mode_o |-> node_addr_o == 8'h00 &&
		baud_code_o == 6'h06 && !checksum_o && !protocol_o; endproperty
	a_init: assert property (p_init) else $error("init settings");
	property p_rst; cmd_valid_i &&
		cmd_code_i == pms_pkg::CMD_READ_RESET_STATUS |=>
		resp_valid_o && resp_data_o[7:1] == 7'h0; endproperty
	a_rst: assert property (p_rst) else $error("flag reply");
	property p_do; cmd_valid_i &&
		cmd_code_i == pms_pkg::CMD_SET_DIGITAL_OUTPUT |=>
		resp_ok_o || $stable(do_o); endproperty
	a_do: assert property (p_do) else $error("do changed");
	property p_com; cmd_valid_i && !init_mode_o &&
		cmd_code_i == pms_pkg::CMD_SET_COMM_CONFIG |=> !resp_ok_o;
	endproperty
	a_com: assert property (p_com) else $error("comm taken");
endmodule : pms_supervisor_monitor
bind pms_supervisor pms_supervisor_monitor #(.NCH(NCH), .DO_W(DO_W)) u_mon (
	.clk_i, .rst_i, .cmd_valid_i, .cmd_code_i, .resp_ok_o, .resp_valid_o,
	.resp_data_o, .nvm_req_o, .nvm_we_o, .mwd_reset_o, .pwm_run_o, .do_o,
	.init_mode_o, .node_addr_o, .baud_code_o, .checksum_o, .protocol_o);

// file: test/testbench.sv
// self-checking bench of the supervisor
`timescale 1ns/1ns
module testbench;
	logic clk_i = 0, rst_i = 1, cyc = 0, we = 0, cv = 0, nack, kick = 1;
	logic init_n = 1, ack, rv, ok, req, nwe, mr;
	logic [7:0] adr = 0, rd, na, dov;
	logic [31:0] dat = 0, q, s = 31, dd;
	logic [15:0] cd = 0;
	logic [33:0] nr, nw;
	logic [2:0] naddr;
	logic [7:0] run;
	logic [191:0] pf;
	logic [79:0] pd;
	pms_pkg::pms_cmd_t cc = pms_pkg::CMD_OTHER;
	int num_errors = 0, comparisons = 0, tick = 0;
	pms_supervisor #(.HWD_UNIT_CYC(20), .MWD_CYC(200)) u_pms_supervisor (
		.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(q),
		.wb_ack_o(ack), .cmd_valid_i(cv), .cmd_code_i(cc), .cmd_data_i(cd),
		.resp_valid_o(rv), .resp_ok_o(ok), .resp_data_o(rd), .nvm_req_o(req),
		.nvm_we_o(nwe), .nvm_addr_o(naddr), .nvm_wdata_o(nw), .nvm_rdata_i(nr),
		.nvm_ack_i(nack), .init_n_i(init_n), .mwd_kick_i(kick),
		.mwd_reset_o(mr), .pwm_run_o(run),
		.pwm_freq_o(pf), .pwm_duty_o(pd),
		.do_o(dov), .node_addr_o(na), .baud_code_o(), .checksum_o(),
		.protocol_o(), .init_mode_o());
	pms_nvm_model u_pms_nvm_model (.clk_i, .req_i(req), .we_i(nwe),
		.addr_i(naddr), .wdata_i(nw), .ack_o(nack), .rdata_o(nr));
	initial forever #4 clk_i = ~clk_i;
	function automatic logic [31:0] xs(input logic [31:0] v);
		v = v ^ (v << 13);
		v = v ^ (v >> 17);
		return v ^ (v << 5);
	endfunction : xs
	task automatic chk(input string n, input logic [33:0] g, e);
		comparisons++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %s exp %h seen %h", n, e, g);
		end
	endtask : chk
	// one classic cycle, held until ack is sampled
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1; we <= w; adr <= a; dat <= d;
		do @(posedge clk_i); while (ack !== 1'b1);
		dd = q;
		cyc <= 0;
	endtask : wb
	task automatic cmd(input pms_pkg::pms_cmd_t c, input logic [15:0] d);
		@(posedge clk_i);
		cv <= 1; cc <= c; cd <= d;
		@(posedge clk_i);
		cv <= 0;
		#1;
	endtask : cmd
	task automatic final_report;
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : final_report
	// hang guard
	always @(posedge clk_i) begin
		tick++;
		if (tick > 20000) begin
			num_errors++;
			final_report();
		end
	end
	initial begin
		repeat (12) @(posedge clk_i);
		rst_i <= 0;
		wait (req); wait (!req);
		wb(0, pms_pkg::OFS_STATUS, 0); chk("loaded", dd[9], 1);
		chk("run", run, 0);
		cmd(pms_pkg::CMD_READ_RESET_STATUS, 0); chk("flag", rd, 1);
		cmd(pms_pkg::CMD_READ_RESET_STATUS, 0); chk("flag2", rd, 0);
		s = xs(s); wb(1, pms_pkg::OFS_CH_SEL, 2);
		wb(1, pms_pkg::OFS_CH_FREQ, 500); wb(1, pms_pkg::OFS_CH_DUTY, s % 999 + 1);
		wb(0, pms_pkg::OFS_CH_DUTY, 0); chk("duty", dd, s % 999 + 1);
		wb(1, pms_pkg::OFS_CH_FREQ, 5000); wb(1, pms_pkg::OFS_CH_DUTY, 5);
		wb(0, pms_pkg::OFS_STATUS, 0); chk("reject", dd[12], 1);
		cmd(pms_pkg::CMD_SAVE_PWM_CONFIG, 0);
		wait (req); wait (!req);
		chk("saved", u_pms_nvm_model.mem[2], {24'd500, 10'(s % 999 + 1)});
		cmd(pms_pkg::CMD_SET_COMM_CONFIG, 16'h0506); chk("comm", ok, 0);
		cmd(pms_pkg::CMD_SELECT_PROTOCOL, 1); chk("proto", ok, 0);
		// top band: any duty is taken but runs at half, band edge plus random
		s = xs(s);
		wb(1, pms_pkg::OFS_CH_FREQ, 32'h2711 + s[19:0]);
		wb(1, pms_pkg::OFS_CH_DUTY, 7);
		chk("half", pd[29:20], pms_pkg::DUTY_HALF);
		chk("hfreq", pf[71:48], 32'h2711 + s[19:0]);
		s = xs(s); wb(1, pms_pkg::OFS_DO_SAFE, s);
		wb(1, pms_pkg::OFS_HWD_TMO, 0); wb(1, pms_pkg::OFS_CTRL, 32'hff01);
		chk("start", run, 8'hff);
		wait (run == 0);
		wb(0, pms_pkg::OFS_STATUS, 0); chk("tmo", dd[7:0], 4);
		chk("safe", dov, s[7:0]);
		wb(1, pms_pkg::OFS_CTRL, 32'hff00); chk("block", run, 0);
		cmd(pms_pkg::CMD_SET_DIGITAL_OUTPUT, 16'h5a); chk("q", rd, 8'h3f);
		cmd(pms_pkg::CMD_CLEAR_MODULE_STAT, 0);
		wb(1, pms_pkg::OFS_CTRL, 32'hff00);
		chk("restart", run, 8'hff);
		wb(0, pms_pkg::OFS_STATUS, 0); chk("clr", dd[7:0], 0);
		cmd(pms_pkg::CMD_SET_DIGITAL_OUTPUT, 16'h5a); chk("do", dov, 8'h5a);
		s = xs(s); wb(1, pms_pkg::OFS_DO_PWRON, s);
		kick <= 0; wait (mr); kick <= 1;
		cmd(pms_pkg::CMD_READ_RESET_STATUS, 0); chk("wflag", rd, 1);
		chk("pwron", dov, s[7:0]);
		chk("wrun", run, 0);
		@(posedge clk_i);
		rst_i <= 1; init_n <= 0;
		repeat (12) @(posedge clk_i);
		rst_i <= 0;
		repeat (6) @(posedge clk_i);
		chk("addr", na, 0);
		wb(0, pms_pkg::OFS_COMM, 0);
		chk("stored", dd[7:0], pms_pkg::RST_NODE_ADDR);
		cmd(pms_pkg::CMD_SET_COMM_CONFIG, 16'h0507); chk("icomm", ok, 1);
		chk("iaddr", na, 0);
		final_report();
	end
endmodule : testbench
